// >>> logic/mmdb_map.svh
// Constants of the memory map decoder: region bases, bit-band layout, port timing.
// Assumes a 10 MHz single clock; included by the package users by bare name.
// Operation
// - Each external memory port access takes four bus clock cycles from start to completion.
// - The external port serves either synchronous or asynchronous memory, one type at a time.
// - The external port drives at most 24 address bits taken from the external RAM region.
// - The external data path is either 8 or 16 bits wide, matching the attached memory.
// - Instruction fetches may be served from external memory, more slowly than from flash.
// - External memory has no code protection; all of it is readable without restriction.
// - Address lines and strobes are produced together with the programmable digital blocks and ports.
// - The map splits into code, SRAM, peripheral, external RAM, external peripheral, internal regions.
// - The top half-gigabyte from 0xE0000000 holds the core's internal peripherals.
// - An alias write sets or clears one SRAM bit from data bit 0; an alias read returns 0 or 1.
// - Aligned words and unaligned words or half-words are accepted; unaligned ones take extra cycles (here only word-crossing internal bus accesses do).
// - The instruction and data code buses carry only accesses inside the code region.
// - The system bus carries data and debug accesses from SRAM to 0xDFFFFFFF, except 0x60000000-0x9FFFFFFF, and from 0xE0100000 up.
// - The system bus also serves instruction fetches inside the SRAM region.
// - System control and debug registers are reached over the private peripheral bus.
`ifndef MMDB_MAP_SVH
`define MMDB_MAP_SVH
`define MMDB_SRAM_BASE 32'h2000_0000
`define MMDB_PERI_BASE 32'h4000_0000
`define MMDB_XRAM_BASE 32'h6000_0000
`define MMDB_XPER_BASE 32'hA000_0000
`define MMDB_INT_BASE 32'hE000_0000
`define MMDB_SYS_HI_BASE 32'hE010_0000
`define MMDB_BAND_BASE 32'h2000_0000
`define MMDB_BAND_TOP 32'h200F_FFFF
`define MMDB_ALIAS_BASE 32'h2200_0000
`define MMDB_ALIAS_TOP 32'h23FF_FFFF
`define MMDB_XADDR_W 24
`define MMDB_XPORT_NS 400
`define MMDB_CLK_NS 100
`define MMDB_XPORT_CYC ((`MMDB_XPORT_NS + `MMDB_CLK_NS - 1) / `MMDB_CLK_NS)
`endif

// >>> logic/mmdb_pkg.sv
// Types shared by the memory map decoder and its helpers.
// Assumes no other package; constants live in mmdb_map.svh.
package mmdb_pkg;
    typedef enum logic [2:0] {
        MMDB_TGT_CODE, MMDB_TGT_SYS, MMDB_TGT_PRIV, MMDB_TGT_XMEM, MMDB_TGT_NONE
    } mmdb_tgt_t;
    typedef enum logic [1:0] {MMDB_SZ_BYTE, MMDB_SZ_HALF, MMDB_SZ_WORD} mmdb_size_t;
    // One upstream request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        mmdb_size_t size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mmdb_req_t;
    // One answer to the core
    typedef struct packed {
        logic done;
        logic error;
        logic [31:0] rdata;
    } mmdb_rsp_t;
    // Simple downstream slave port: request held valid until ready, ready, data
    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] strb;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mmdb_dreq_t;
    typedef struct packed {
        logic ready;
        logic error;
        logic [31:0] rdata;
    } mmdb_drsp_t;
    // External memory pins as handed to the port logic
    typedef struct packed {
        logic cs;
        logic oe;
        logic we;
        logic [23:0] addr;
        logic [15:0] dout;
        logic dout_en;
    } mmdb_xpin_t;
endpackage

// >>> logic/mmdb_decode.sv
// Address decoder: maps an address and fetch flag onto one downstream target.
// Assumes a purely combinational use inside the router.
`include "mmdb_map.svh"
module mmdb_decode (
    input wire logic [31:0] addr,
    input wire logic fetch,
    output mmdb_pkg::mmdb_tgt_t tgt,
    output logic alias_hit
);
    import mmdb_pkg::*;
    // Region decode by address range
    always_comb begin
        alias_hit = (addr >= `MMDB_ALIAS_BASE) && (addr <= `MMDB_ALIAS_TOP);
        if (addr < `MMDB_SRAM_BASE) begin
            tgt = MMDB_TGT_CODE;
        end else if (addr < `MMDB_PERI_BASE) begin
            tgt = MMDB_TGT_SYS;
        end else if (addr < `MMDB_XRAM_BASE) begin
            tgt = fetch ? MMDB_TGT_NONE : MMDB_TGT_SYS;
        end else if (addr < `MMDB_XPER_BASE) begin
            tgt = MMDB_TGT_XMEM;
        end else if (addr < `MMDB_INT_BASE) begin
            tgt = fetch ? MMDB_TGT_NONE : MMDB_TGT_SYS;
        end else if (addr < `MMDB_SYS_HI_BASE) begin
            tgt = fetch ? MMDB_TGT_NONE : MMDB_TGT_PRIV;
        end else begin
            tgt = fetch ? MMDB_TGT_NONE : MMDB_TGT_SYS;
        end
    end
endmodule // mmdb_decode

// >>> logic/mmdb_xport.sv
// External memory port sequencer: one access in four bus clocks, 8 or 16 bit device.
// Assumes pins are routed out through the programmable digital blocks and ports.
`include "mmdb_map.svh"
module mmdb_xport (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic write,
    input wire logic [23:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wide,
    input wire logic sync_mode,
    input wire logic [15:0] pin_din,
    output mmdb_pkg::mmdb_xpin_t pins,
    output logic done,
    output logic [15:0] rdata
);
    import mmdb_pkg::*;
    typedef struct packed {
        logic busy;
        logic [2:0] cnt;
        mmdb_xpin_t pins;
        logic done;
        logic [15:0] rdata;
    } mmdb_xst_t;
    localparam logic [2:0] LAST = 3'(`MMDB_XPORT_CYC - 1);
    mmdb_xst_t st, next_st;
    // Strobe sequence; async devices see oe/we only in the middle cycles
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (!st.busy && start) begin
            next_st.busy = 1'b1;
            next_st.cnt = 3'h0;
            next_st.pins.cs = 1'b1;
            next_st.pins.addr = addr;
            next_st.pins.dout = wide ? wdata : {8'h00, wdata[7:0]};
            next_st.pins.dout_en = write;
            next_st.pins.oe = !write && sync_mode;
            next_st.pins.we = write && sync_mode;
        end else if (st.busy) begin
            next_st.cnt = st.cnt + 3'h1;
            if (st.cnt == 3'h0) begin
                next_st.pins.oe = !st.pins.dout_en;
                next_st.pins.we = st.pins.dout_en;
            end
            if (st.cnt == LAST - 3'h1) begin
                next_st.rdata = wide ? pin_din : {8'h00, pin_din[7:0]};
                next_st.pins.oe = 1'b0;
                next_st.pins.we = 1'b0;
            end
            if (st.cnt == LAST) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
                next_st.pins = '0;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign pins = st.pins;
    assign done = st.done;
    assign rdata = st.rdata;
endmodule // mmdb_xport

// >>> logic/mmdb_router.sv
// Memory map router: steers core accesses to code, system, private peripheral or
// external memory, performs bit-band alias read-modify-write, splits word-crossing
// and wide transfers. Assumes downstream slaves answer with a ready level.
`include "mmdb_map.svh"
module mmdb_router (
    input wire logic clk,
    input wire logic rst_n,
    input mmdb_pkg::mmdb_req_t req,
    output mmdb_pkg::mmdb_rsp_t rsp,
    output logic req_ready,
    output mmdb_pkg::mmdb_dreq_t code_req,
    input mmdb_pkg::mmdb_drsp_t code_rsp,
    output mmdb_pkg::mmdb_dreq_t sys_req,
    input mmdb_pkg::mmdb_drsp_t sys_rsp,
    output mmdb_pkg::mmdb_dreq_t priv_req,
    input mmdb_pkg::mmdb_drsp_t priv_rsp,
    input wire logic xmem_wide,
    input wire logic xmem_sync,
    input wire logic [15:0] xmem_din,
    output mmdb_pkg::mmdb_xpin_t xmem_pins
);
    import mmdb_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_BUS, ST_ALIAS_RD, ST_ALIAS_WR, ST_XMEM, ST_XWAIT, ST_ANSWER
    } mmdb_state_t;

    typedef struct packed {
        mmdb_state_t state;
        mmdb_tgt_t tgt;
        logic write;
        mmdb_size_t size;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [4:0] bitpos;
        logic part;
        logic [1:0] xbeat;
        logic [1:0] xlast;
        mmdb_rsp_t rsp;
        mmdb_dreq_t dreq;
    } mmdb_st_t;

    mmdb_st_t st, next_st;
    mmdb_tgt_t dec_tgt;
    logic dec_alias;
    logic x_done;
    logic [15:0] x_rdata;
    logic x_start;
    logic [23:0] x_addr;
    logic [15:0] x_wdata;
    mmdb_drsp_t sel_rsp;
    logic [31:0] band_word;
    logic [3:0] lane_strb;
    logic [1:0] word_off;
    logic [31:0] rot_wdata;
    logic [31:0] rot_rdata;

    mmdb_decode u_decode (
        .addr(req.addr),
        .fetch(req.fetch),
        .tgt(dec_tgt),
        .alias_hit(dec_alias)
    );

    mmdb_xport u_xport (
        .clk(clk),
        .rst_n(rst_n),
        .start(x_start),
        .write(st.write),
        .addr(x_addr),
        .wdata(x_wdata),
        .wide(xmem_wide),
        .sync_mode(xmem_sync),
        .pin_din(xmem_din),
        .pins(xmem_pins),
        .done(x_done),
        .rdata(x_rdata)
    );

    // Answer of whichever internal bus the current access went to
    always_comb begin
        case (st.tgt)
            MMDB_TGT_CODE: sel_rsp = code_rsp;
            MMDB_TGT_PRIV: sel_rsp = priv_rsp;
            default: sel_rsp = sys_rsp;
        endcase
    end

    // Bit-band: word offset w and bit n from alias address 0x22000000+32w+4n
    // Each SRAM word owns 128 alias bytes, so the word index is addr[24:7]
    assign band_word = `MMDB_BAND_BASE + {12'h000, req.addr[24:7], 2'b00};

    // Byte lanes for the current part of an access; a word-crossing access spills into a second word
    assign word_off = st.addr[1:0];
    always_comb begin
        case (st.size)
            MMDB_SZ_BYTE: lane_strb = 4'h1 << word_off;
            MMDB_SZ_HALF: lane_strb = 4'(4'h3 << word_off);
            default: lane_strb = 4'(4'hF << word_off);
        endcase
        if (st.part) begin
            lane_strb = (st.size == MMDB_SZ_HALF) ? 4'h1 : 4'(4'hF >> (3'h4 - {1'b0, word_off}));
        end
    end
    assign rot_wdata = st.part ? (st.wdata >> (6'(4 - word_off) * 6'h08))
                               : (st.wdata << ({3'h0, word_off} * 5'h08));
    assign rot_rdata = sel_rsp.rdata >> ({3'h0, word_off} * 5'h08);

    // External port sees the region offset; only 24 bits leave the chip
    assign x_addr = st.addr[`MMDB_XADDR_W-1:0] + {22'h0, st.xbeat};
    assign x_wdata = xmem_wide ? (st.xbeat[1] ? st.wdata[31:16] : st.wdata[15:0])
                               : {8'h00, st.wdata[8*st.xbeat +: 8]};
    assign x_start = (st.state == ST_XMEM);

    // Main sequencer
    always_comb begin
        next_st = st;
        next_st.rsp.done = 1'b0;
        next_st.rsp.error = 1'b0;
        case (st.state)
            ST_IDLE: begin
                if (req.valid) begin
                    next_st.write = req.write;
                    next_st.size = req.size;
                    next_st.wdata = req.wdata;
                    next_st.rdata = 32'h0000_0000;
                    next_st.addr = req.addr;
                    next_st.tgt = dec_tgt;
                    next_st.part = 1'b0;
                    next_st.xbeat = 2'h0;
                    next_st.bitpos = req.addr[6:2];
                    next_st.dreq.write = req.write;
                    if (dec_tgt == MMDB_TGT_NONE) begin
                        next_st.state = ST_ANSWER;
                        next_st.rsp.error = 1'b1;
                        next_st.rsp.done = 1'b1;
                        next_st.rsp.rdata = 32'h0000_0000;
                        next_st.state = ST_IDLE;
                    end else if (dec_alias) begin
                        next_st.addr = band_word;
                        next_st.tgt = MMDB_TGT_SYS;
                        next_st.state = ST_ALIAS_RD;
                        next_st.dreq.write = 1'b0;
                        next_st.dreq.strb = 4'hF;
                        next_st.dreq.addr = band_word;
                        next_st.dreq.valid = 1'b1;
                    end else if (dec_tgt == MMDB_TGT_XMEM) begin
                        next_st.addr = req.addr - `MMDB_XRAM_BASE;
                        next_st.xlast = (req.size == MMDB_SZ_WORD) ? (xmem_wide ? 2'h2 : 2'h3)
                                      : (req.size == MMDB_SZ_HALF && !xmem_wide) ? 2'h1 : 2'h0;
                        next_st.state = ST_XMEM;
                    end else begin
                        next_st.state = ST_BUS;
                        next_st.dreq.valid = 1'b1;
                        next_st.dreq.addr = {req.addr[31:2], 2'b00};
                    end
                end
            end
            ST_BUS: begin
                next_st.dreq.strb = lane_strb;
                next_st.dreq.wdata = rot_wdata;
                if (sel_rsp.ready) begin
                    next_st.rdata = st.part ? (st.rdata | (sel_rsp.rdata << (6'(4 - word_off) * 6'h08)))
                                            : rot_rdata;
                    if (!st.part && !sel_rsp.error &&
                        ({1'b0, word_off} + ((st.size == MMDB_SZ_WORD) ? 3'h4 :
                          (st.size == MMDB_SZ_HALF) ? 3'h2 : 3'h1)) > 3'h4) begin
                        next_st.part = 1'b1;
                        next_st.dreq.addr = st.dreq.addr + 32'h0000_0004;
                    end else begin
                        next_st.dreq.valid = 1'b0;
                        next_st.rsp.error = sel_rsp.error;
                        next_st.state = ST_ANSWER;
                    end
                end
            end
            ST_ALIAS_RD: begin
                if (sys_rsp.ready) begin
                    if (sys_rsp.error || !st.write) begin
                        next_st.dreq.valid = 1'b0;
                        next_st.rdata = {31'h0, sys_rsp.rdata[st.bitpos]};
                        next_st.rsp.error = sys_rsp.error;
                        next_st.state = ST_ANSWER;
                    end else begin
                        next_st.dreq.write = 1'b1;
                        next_st.dreq.wdata = sys_rsp.rdata;
                        next_st.dreq.wdata[st.bitpos] = st.wdata[0];
                        next_st.state = ST_ALIAS_WR;
                    end
                end
            end
            ST_ALIAS_WR: begin
                if (sys_rsp.ready) begin
                    next_st.dreq.valid = 1'b0;
                    next_st.rsp.error = sys_rsp.error;
                    next_st.state = ST_ANSWER;
                end
            end
            ST_XMEM: begin
                next_st.state = ST_XWAIT;
            end
            ST_XWAIT: begin
                if (x_done) begin
                    if (xmem_wide) begin
                        next_st.rdata[16*st.xbeat[1] +: 16] = x_rdata;
                    end else begin
                        next_st.rdata[8*st.xbeat +: 8] = x_rdata[7:0];
                    end
                    if (st.xbeat >= st.xlast) begin
                        next_st.state = ST_ANSWER;
                    end else begin
                        next_st.xbeat = st.xbeat + (xmem_wide ? 2'h2 : 2'h1);
                        next_st.state = ST_XMEM;
                    end
                end
            end
            ST_ANSWER: begin
                // Error answer also ends the access so the bus never hangs
                next_st.rsp.done = 1'b1;
                next_st.rsp.error = st.rsp.error;
                next_st.rsp.rdata = st.write ? 32'h0000_0000 : st.rdata;
                next_st.state = ST_IDLE;
            end
            default: next_st.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Only one request in flight; handshake is combinational
    assign req_ready = (st.state == ST_IDLE);
    assign rsp = st.rsp;
    assign code_req = (st.tgt == MMDB_TGT_CODE) ? st.dreq : '0;
    assign sys_req = (st.tgt == MMDB_TGT_SYS) ? st.dreq : '0;
    assign priv_req = (st.tgt == MMDB_TGT_PRIV) ? st.dreq : '0;
endmodule // mmdb_router

// >>> tb/mmdb_router_checker.sv
// Port checker for mmdb_router: routing by region, external strobes, alias reads.
// Assumes one clock and async active-low reset; bound at the file's foot.
module mmdb_router_checker (
    input wire logic clk,
    input wire logic rst_n,
    input mmdb_pkg::mmdb_req_t req,
    input mmdb_pkg::mmdb_rsp_t rsp,
    input wire logic req_ready,
    input mmdb_pkg::mmdb_dreq_t code_req,
    input mmdb_pkg::mmdb_dreq_t sys_req,
    input mmdb_pkg::mmdb_dreq_t priv_req,
    input wire logic xmem_sync,
    input mmdb_pkg::mmdb_xpin_t xmem_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    import mmdb_pkg::*;
    logic taken;
    logic stb;
    mmdb_req_t last;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign taken = req.valid && req_ready;
    assign stb = xmem_pins.oe || xmem_pins.we;
    // Remember the request being answered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last <= '0;
        end else if (taken) begin
            last <= req;
        end
    end
    property p_bad_fetch;
        taken && req.fetch && !(req.addr inside {[32'h0:32'h3FFF_FFFF], [32'h6000_0000:32'h9FFF_FFFF]})
            |-> ##1 rsp.done && rsp.error;
    endproperty
    a_bad_fetch: assert property (p_bad_fetch)
        else $error("fetch outside code, sram or external ram not refused");
    property p_code;
        code_req.valid |-> code_req.addr < 32'h2000_0000;
    endproperty
    a_code: assert property (p_code)
        else $error("code bus outside code region");
    property p_priv;
        priv_req.valid |-> priv_req.addr inside {[32'hE000_0000:32'hE00F_FFFF]};
    endproperty
    a_priv: assert property (p_priv)
        else $error("private bus outside its window");
    property p_sys;
        taken && !req.fetch && req.size == MMDB_SZ_WORD && req.addr[1:0] == 2'h0
            && req.addr inside {[32'h4000_0000:32'h5FFF_FFFF]}
            |-> ##1 sys_req.valid && sys_req.addr == $past(req.addr);
    endproperty
    a_sys: assert property (p_sys)
        else $error("peripheral access not on system bus");
    property p_cs_len;
        $rose(xmem_pins.cs) |-> xmem_pins.cs[*4] ##1 !xmem_pins.cs;
    endproperty
    a_cs_len: assert property (p_cs_len)
        else $error("external access not four cycles");
    property p_async;
        $rose(xmem_pins.cs) && !xmem_sync |-> !stb ##1 stb[*2] ##1 !stb;
    endproperty
    a_async: assert property (p_async)
        else $error("async strobes misplaced");
    property p_sync;
        $rose(xmem_pins.cs) && xmem_sync |-> stb[*3] ##1 !stb;
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync strobes misplaced");
    property p_alias;
        rsp.done && !last.write && last.addr inside {[32'h2200_0000:32'h23FF_FFFF]}
            |-> rsp.rdata[31:1] == 31'h0;
    endproperty
    a_alias: assert property (p_alias)
        else $error("alias read wider than one bit");
endmodule // mmdb_router_checker

bind mmdb_router mmdb_router_checker i_chk (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp),
    .req_ready(req_ready), .code_req(code_req), .sys_req(sys_req), .priv_req(priv_req),
    .xmem_sync(xmem_sync), .xmem_pins(xmem_pins));

// >>> tb/mmdb_far_models.sv
// Far-side models: an internal bus slave and an external memory device.
// Assumes the router's request structs and the bench's clock.
module mmdb_slave_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input mmdb_pkg::mmdb_dreq_t dreq,
    output mmdb_pkg::mmdb_drsp_t drsp
);
    timeunit 1ns;
    timeprecision 1ns;
    import mmdb_pkg::*;
    bit [31:0] mem [bit [31:0]];
    logic [2:0] cnt;
    logic rdy;
    // Ready no earlier than the third valid cycle, strobes settle late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            rdy <= 1'b0;
        end else if (!dreq.valid || rdy) begin
            cnt <= '0;
            rdy <= 1'b0;
        end else if (cnt == (slow ? 3'h4 : 3'h1)) begin
            rdy <= 1'b1;
        end else begin
            cnt <= cnt + 3'h1;
        end
    end
    // Byte lanes written at the accepting edge
    always @(posedge clk) begin
        if (dreq.valid && rdy && dreq.write) begin
            for (int i = 0; i < 4; i++) begin
                if (dreq.strb[i]) mem[dreq.addr][8*i+:8] = dreq.wdata[8*i+:8];
            end
        end
    end
    // Data outside the answer cycle is junk on purpose
    assign drsp = '{ready: rdy, error: 1'b0, rdata: rdy ? mem[dreq.addr] : ~mem[dreq.addr]};
endmodule // mmdb_slave_model

module mmdb_xmem_model (
    input wire logic clk,
    input wire logic wide,
    input mmdb_pkg::mmdb_xpin_t pins,
    output logic [15:0] din,
    output int beats,
    output logic [23:0] xlast
);
    timeunit 1ns;
    timeprecision 1ns;
    bit [15:0] mem [bit [23:0]];
    logic [15:0] held = 16'h0;
    logic cs_d = 1'b0;
    logic rd_en;
    initial beats = 0;
    // Count beats and keep the address of the last one
    always @(posedge clk) begin
        cs_d <= pins.cs;
        if (pins.cs && !cs_d) begin
            beats <= beats + 1;
            xlast <= pins.addr;
        end
        if (pins.cs && pins.we && pins.dout_en) mem[pins.addr] = wide ? pins.dout : {8'h00, pins.dout[7:0]};
        if (rd_en) held <= din;
    end
    // Undriven lines show the inverse of their last value
    assign rd_en = pins.cs && pins.oe;
    assign din[7:0] = rd_en ? mem[pins.addr][7:0] : ~held[7:0];
    assign din[15:8] = (rd_en && wide) ? mem[pins.addr][15:8] : ~held[15:8];
endmodule // mmdb_xmem_model

// >>> tb/tb_memory_map_decoder_bitband.sv
// Self-checking bench for mmdb_router with bus slaves and external memory.
// Assumes the checker is bound to the router by its own file.
module tb_memory_map_decoder_bitband;
    timeunit 1ns;
    timeprecision 1ns;
    import mmdb_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wide = 1'b1;
    logic sync = 1'b0;
    logic slow = 1'b0;
    mmdb_req_t req = '0;
    mmdb_rsp_t rsp;
    logic req_ready;
    mmdb_dreq_t cq, sq, pq;
    mmdb_drsp_t cr, sr, pr;
    mmdb_xpin_t pins;
    logic [15:0] din;
    logic [23:0] xlast;
    logic [31:0] rd;
    logic er;
    int beats, b, err_total = 0, cmp_count = 0;
    always #50 clk = ~clk;
    mmdb_router i_dut (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp), .req_ready(req_ready),
        .code_req(cq), .code_rsp(cr), .sys_req(sq), .sys_rsp(sr), .priv_req(pq), .priv_rsp(pr),
        .xmem_wide(wide), .xmem_sync(sync), .xmem_din(din), .xmem_pins(pins));
    mmdb_slave_model i_code (.clk(clk), .rst_n(rst_n), .slow(slow), .dreq(cq), .drsp(cr));
    mmdb_slave_model i_sys (.clk(clk), .rst_n(rst_n), .slow(slow), .dreq(sq), .drsp(sr));
    mmdb_slave_model i_priv (.clk(clk), .rst_n(rst_n), .slow(slow), .dreq(pq), .drsp(pr));
    mmdb_xmem_model i_xmem (.clk(clk), .wide(wide), .pins(pins), .din(din), .beats(beats),
        .xlast(xlast));
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One core access; held until taken, answer waited for under a bound
    task automatic acc(logic w, logic f, mmdb_size_t sz, logic [31:0] a, logic [31:0] d);
        int n;
        n = 0;
        req <= '{valid: 1'b1, write: w, fetch: f, size: sz, addr: a, wdata: d};
        @(posedge clk);
        while (req_ready !== 1'b1) begin
            n++;
            if (n > 300) chk(32'h0, 32'h1);
            if (n > 300) report_and_stop();
            @(posedge clk);
        end
        req.valid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
            if (n > 300) chk(32'h0, 32'h1);
            if (n > 300) report_and_stop();
        end while (rsp.done !== 1'b1);
        rd = rsp.rdata;
        er = rsp.error;
    endtask
    // Aligned and word-crossing accesses, prompt and slow slaves
    task automatic t_sram;
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            acc(1'b1, 1'b0, MMDB_SZ_WORD, 32'h2000_0010, 32'hA5A5_1234);
            acc(1'b1, 1'b0, MMDB_SZ_WORD, 32'h2000_0016, 32'h7788_99AA);
            acc(1'b0, 1'b0, MMDB_SZ_WORD, 32'h2000_0010, 32'h0);
            chk(rd, 32'hA5A5_1234);
            acc(1'b0, 1'b0, MMDB_SZ_WORD, 32'h2000_0016, 32'h0);
            chk(rd, 32'h7788_99AA);
            acc(1'b0, 1'b0, MMDB_SZ_HALF, 32'h2000_0013, 32'h0);
            chk({16'h0, rd[15:0]}, 32'h0000_00A5);
        end
        slow <= 1'b0;
    endtask
    // Alias set, read, clear; a second word and top bit
    task automatic t_band;
        acc(1'b1, 1'b0, MMDB_SZ_WORD, 32'h2000_0000, 32'h0);
        acc(1'b1, 1'b0, MMDB_SZ_WORD, 32'h2200_000C, 32'h1);
        acc(1'b0, 1'b0, MMDB_SZ_WORD, 32'h2000_0000, 32'h0);
        chk(rd, 32'h8);
        acc(1'b0, 1'b0, MMDB_SZ_WORD, 32'h2200_000C, 32'h0);
        chk(rd, 32'h1);
        // Word at offset 4, bit 31: 0x22000000 + 32*4 + 4*31
        acc(1'b1, 1'b0, MMDB_SZ_WORD, 32'h2200_00FC, 32'hFFFF_FFFF);
        acc(1'b0, 1'b0, MMDB_SZ_WORD, 32'h2000_0004, 32'h0);
        chk(rd, 32'h8000_0000);
        acc(1'b1, 1'b0, MMDB_SZ_WORD, 32'h2200_000C, 32'hFFFF_FFFE);
        acc(1'b0, 1'b0, MMDB_SZ_WORD, 32'h2000_0000, 32'h0);
        chk(rd, 32'h0);
    endtask
    // Round trips by region, then fetches that must or must not fail
    task automatic t_route;
        logic [31:0] ok [6] = '{32'h1FFF_FFFC, 32'h0000_0100, 32'hE000_E100, 32'hE010_0000,
            32'h4000_5400, 32'hA000_0040};
        logic [31:0] bad [3] = '{32'h4000_0000, 32'hA000_0000, 32'hE000_0000};
        foreach (ok[i]) begin
            acc(1'b1, 1'b0, MMDB_SZ_WORD, ok[i], ok[i] ^ 32'h5A5A_0F0F);
            acc(1'b0, 1'b0, MMDB_SZ_WORD, ok[i], 32'h0);
            chk(rd, ok[i] ^ 32'h5A5A_0F0F);
        end
        acc(1'b0, 1'b1, MMDB_SZ_WORD, 32'h0000_0100, 32'h0);
        chk(rd, 32'h5A5A_0E0F);
        acc(1'b0, 1'b1, MMDB_SZ_WORD, 32'h2000_0010, 32'h0);
        chk({31'h0, er}, 32'h0);
        foreach (bad[i]) begin
            acc(1'b0, 1'b1, MMDB_SZ_WORD, bad[i], 32'h0);
            chk({31'h0, er}, 32'h1);
        end
    endtask
    // Every width and device type: beats, address, fetch and half read
    task automatic t_ext;
        logic [31:0] a;
        for (int m = 0; m < 4; m++) begin
            wide <= m[0];
            sync <= m[1];
            a = 32'h6012_3400 + 32'(m * 16);
            b = beats;
            acc(1'b1, 1'b0, MMDB_SZ_WORD, a, 32'h1122_3344 + 32'(m));
            chk(32'(beats - b), m[0] ? 32'h2 : 32'h4);
            chk({8'h0, xlast}, a - 32'h6000_0000 + (m[0] ? 32'h2 : 32'h3));
            acc(1'b0, 1'b1, MMDB_SZ_WORD, a, 32'h0);
            chk(rd, 32'h1122_3344 + 32'(m));
            chk({31'h0, er}, 32'h0);
            b = beats;
            acc(1'b0, 1'b0, MMDB_SZ_HALF, a + 32'h2, 32'h0);
            chk({16'h0, rd[15:0]}, 32'h1122);
            chk(32'(beats - b), m[0] ? 32'h1 : 32'h2);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_sram();
        t_band();
        t_route();
        t_ext();
        report_and_stop();
    end
endmodule // tb_memory_map_decoder_bitband
